// File: hw/umlc_pkg.sv
// Package for the modem line control block: register map, field layout, timing.
// Assumes a single 200 MHz core clock and a plain strobe register port.
package umlc_pkg;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 32;
    // Register offsets (byte addresses, one word each).
    localparam logic [3:0]  OFF_CTRL       = 4'h0;
    localparam logic [3:0]  OFF_CFG        = 4'h4;
    localparam logic [3:0]  OFF_STATUS     = 4'h8;
    localparam logic [3:0]  OFF_MUXCH      = 4'hc;
    // Control register fields.
    localparam int          CTRL_DATA_MODE = 0;
    localparam int          CTRL_CARRIER   = 1;
    localparam int          CTRL_MUX_START = 2;
    localparam int          CTRL_MUX_STOP  = 3;
    localparam int          CTRL_PORT_RDY  = 4;
    localparam int          CTRL_MUX_FCON  = 5;
    localparam int          CTRL_OK_CLR    = 6;
    // Configuration register fields.
    localparam int          CFG_BAUD_LSB   = 0;
    localparam int          CFG_FRAME_LSB  = 8;
    localparam int          CFG_FLOW_LSB   = 12;
    localparam int          CFG_DSR_BIT    = 16;
    localparam int          CFG_DTR_BIT    = 17;
    localparam int          CFG_DCD_BIT    = 18;
    localparam int          CFG_PSV_LSB    = 20;
    localparam int          CFG_CTS_OVR    = 24;
    // Reset values of settings, and the RTS power saving value PSV_RTS.
    localparam logic [7:0]  BAUD_AUTO      = 8'h00;
    localparam logic [3:0]  FRAME_AUTO     = 4'h0;
    localparam logic [3:0]  FLOW_HW        = 4'h3;
    localparam logic        DSR_FOLLOW     = 1'b1;
    localparam logic        DTR_ONLINE     = 1'b1;
    localparam logic        DCD_FOLLOW     = 1'b1;
    localparam logic [3:0]  PSV_OFF        = 4'h0;
    localparam logic [3:0]  PSV_RTS        = 4'h2;
    // Mux channel map.
    localparam logic [2:0]  CH_CONTROL     = 3'h0;
    localparam logic [2:0]  CH_GNSS        = 3'h6;
    localparam logic [2:0]  CH_SIM         = 3'h7;
    // Pin levels: ON is low, OFF is high.
    localparam logic        LVL_ON         = 1'b0;
    localparam logic        LVL_OFF        = 1'b1;
    // Pins float for this long at switch-on before their reset level.
    localparam int          TRI_NS         = 100;
    localparam int          CLK_NS         = 5;
    localparam int          TRI_CYC        = (TRI_NS + CLK_NS - 1) / CLK_NS;
endpackage : umlc_pkg

// File: hw/umlc_tx_ser.sv
// Serializer for the data output line, 8N1 with a programmable bit time.
// Assumes the caller holds the byte stable while busy is high.
`timescale 1ns/1ps
module umlc_tx_ser #(
    parameter int BIT_CYC = 1736
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [7:0] data,
    input  wire logic       enable,
    output logic            line,
    output logic            busy,
    output logic            char_done
);
    initial begin
        if (BIT_CYC < 2) $error("BIT_CYC too small");
    end

    typedef struct packed {
        logic [9:0]  shift;
        logic [3:0]  nbit;
        logic [15:0] cnt;
        logic        busy;
        logic        line;
        logic        done;
    } umlc_ser_t;

    umlc_ser_t s_reg;
    umlc_ser_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (!s_reg.busy) begin
            s_next.line = umlc_pkg::LVL_OFF;
            if (start && enable) begin
                s_next.busy  = 1'b1;
                s_next.shift = {1'b1, data, 1'b0};
                s_next.nbit  = 4'h0;
                s_next.cnt   = 16'h0000;
                s_next.line  = 1'b0;
            end
        end else if (s_reg.cnt == 16'(BIT_CYC - 1)) begin
            s_next.cnt = 16'h0000;
            if (s_reg.nbit == 4'h9) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.line = umlc_pkg::LVL_OFF;
            end else begin
                s_next.nbit  = s_reg.nbit + 4'h1;
                s_next.shift = {1'b1, s_reg.shift[9:1]};
                s_next.line  = s_reg.shift[1];
            end
        end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{shift: 10'h3ff, nbit: 4'h0, cnt: 16'h0000, busy: 1'b0,
                       line: 1'b1, done: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign line      = s_reg.line;
    assign busy      = s_reg.busy;
    assign char_done = s_reg.done;
endmodule : umlc_tx_ser

// File: hw/umlc_top.sv
// Modem-side line control of a V.24 serial port: handshake lines, mode and mux state.
// Assumes the DTE pins are synchronous to CORE_CLK; software sits on the register port.
`timescale 1ns/1ps

module umlc_top #(
    parameter int BIT_CYC   = 1736,
    parameter bit ONE_SHOT  = 1'b0,
    parameter bit EARLY_VER = 1'b0,
    parameter bit HAS_SIM   = 1'b1
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        TXD_IN,
    output logic             TXD_PULLUP,
    output logic             RXD_OUT,
    output logic             RXD_OE_N,
    output logic             CTS_OUT,
    output logic             CTS_OE_N,
    output logic             DSR_OUT,
    output logic             DSR_OE_N,
    output logic             DCD_OUT,
    output logic             DCD_OE_N,
    input  wire logic        RTS_IN,
    input  wire logic        DTR_IN,
    input  wire logic        TX_VALID,
    input  wire logic [7:0]  TX_DATA,
    output logic             TX_READY,
    input  wire logic        RX_CHAR,
    output logic             RX_TO_CMD,
    output logic             RX_DISCARD,
    input  wire logic [2:0]  MUX_CH,
    output logic      [2:0]  MUX_CH_KIND,
    output logic             MUX_FC_ON,
    output logic             ACTIVE_MODE
);
    initial begin
        if (BIT_CYC < 2 || BIT_CYC > 65535) $error("BIT_CYC out of range");
    end

    typedef enum {ST_FLOAT, ST_RESETLVL, ST_RUN} umlc_phase_t;
    typedef enum logic [1:0] {MD_CMD, MD_DATA, MD_ONLINE_CMD} umlc_mode_t;

    typedef struct packed {
        umlc_phase_t phase;
        logic [7:0]  tri_cnt;
        umlc_mode_t  mode;
        logic        carrier;
        logic        mux_on;
        logic        mux_fcon;
        logic        port_rdy;
        logic [7:0]  baud;
        logic [3:0]  frame;
        logic [3:0]  flow;
        logic        dsr_cfg;
        logic        dtr_cfg;
        logic        dcd_cfg;
        logic [3:0]  psv;
        logic        cts_ovr;
        logic        auto_done;
        logic        ok_flag;
        logic        dtr_prev;
        logic        rts_prev;
        logic        asleep;
        logic        rts_stop;
        logic [1:0]  chars_after;
        logic [31:0] rdata;
    } umlc_state_t;

    umlc_state_t s_reg;
    umlc_state_t s_next;

    logic tx_start;
    logic tx_line;
    logic tx_busy;
    logic tx_done;
    logic hw_flow;
    logic cts_lvl;
    logic running;
    logic ok_set;

    ////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] ch_kind(input logic [2:0] ch, input logic sim_ok);
        logic [2:0] k;
        k = 3'h1;
        if (ch == umlc_pkg::CH_CONTROL) k = 3'h0;
        else if (ch == umlc_pkg::CH_GNSS) k = 3'h2;
        else if (ch == umlc_pkg::CH_SIM) k = sim_ok ? 3'h3 : 3'h7;
        return k;
    endfunction : ch_kind

    assign running = (s_reg.phase == ST_RUN);
    assign hw_flow = (s_reg.flow == umlc_pkg::FLOW_HW);

    // The transmitter stops between characters, so RTS OFF costs at most one
    // character: the one in flight or one started in the same cycle.
    assign tx_start = running && TX_VALID && !s_reg.rts_stop;
    assign TX_READY = tx_start && !tx_busy;

    umlc_tx_ser #(
        .BIT_CYC (BIT_CYC)
    ) u_ser (
        .clk       (CORE_CLK),
        .rst_n     (RESET_N),
        .start     (tx_start),
        .data      (TX_DATA),
        .enable    (running),
        .line      (tx_line),
        .busy      (tx_busy),
        .char_done (tx_done)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next         = s_reg;
        ok_set         = 1'b0;
        s_next.rdata   = 32'h0000_0000;
        s_next.dtr_prev = DTR_IN;
        s_next.rts_prev = RTS_IN;
        case (s_reg.phase)
            ST_FLOAT: begin
                if (s_reg.tri_cnt == 8'(umlc_pkg::TRI_CYC - 1)) s_next.phase = ST_RESETLVL;
                else s_next.tri_cnt = s_reg.tri_cnt + 8'h01;
            end
            ST_RESETLVL: s_next.phase = ST_RUN;
            ST_RUN: begin
                // DTR going from ON to OFF (pin low to high) ends data mode.
                if (s_reg.dtr_cfg && s_reg.dtr_prev == umlc_pkg::LVL_ON
                    && DTR_IN == umlc_pkg::LVL_OFF && s_reg.mode == MD_DATA) begin
                    s_next.mode    = MD_ONLINE_CMD;
                    s_next.ok_flag = 1'b1;
                    ok_set         = 1'b1;
                end
                // One-shot auto detection locks after the first character.
                if (RX_CHAR && ONE_SHOT) s_next.auto_done = 1'b1;
                // RTS driven power saving without hardware flow.
                if (!hw_flow && s_reg.psv == umlc_pkg::PSV_RTS) begin
                    if (RTS_IN == umlc_pkg::LVL_OFF) s_next.asleep = 1'b1;
                    else s_next.asleep = 1'b0;
                    if (RX_CHAR && s_reg.asleep) s_next.asleep = 1'b0;
                end else begin
                    s_next.asleep = 1'b0;
                end
                // RTS flow stop towards the DTE.
                if (hw_flow && RTS_IN == umlc_pkg::LVL_OFF) begin
                    if (s_reg.rts_prev == umlc_pkg::LVL_ON) s_next.chars_after = 2'h0;
                    else if (tx_done && s_reg.chars_after != 2'h2)
                        s_next.chars_after = s_reg.chars_after + 2'h1;
                    s_next.rts_stop = 1'b1;
                end else begin
                    s_next.rts_stop = 1'b0;
                end
            end
            default: s_next.phase = ST_FLOAT;
        endcase

        if (WR) begin
            case (ADDR)
                umlc_pkg::OFF_CTRL: begin
                    if (WDATA[umlc_pkg::CTRL_DATA_MODE]) s_next.mode = MD_DATA;
                    else if (s_reg.mode == MD_DATA) s_next.mode = MD_CMD;
                    s_next.carrier  = WDATA[umlc_pkg::CTRL_CARRIER];
                    s_next.port_rdy = WDATA[umlc_pkg::CTRL_PORT_RDY];
                    s_next.mux_fcon = WDATA[umlc_pkg::CTRL_MUX_FCON];
                    if (WDATA[umlc_pkg::CTRL_MUX_START]) s_next.mux_on = 1'b1;
                    if (WDATA[umlc_pkg::CTRL_MUX_STOP]) s_next.mux_on = 1'b0;
                    // A new OK event in the same cycle wins over the clear.
                    if (WDATA[umlc_pkg::CTRL_OK_CLR] && !ok_set)
                        s_next.ok_flag = 1'b0;
                end
                umlc_pkg::OFF_CFG: begin
                    s_next.baud    = WDATA[umlc_pkg::CFG_BAUD_LSB +: 8];
                    s_next.frame   = WDATA[umlc_pkg::CFG_FRAME_LSB +: 4];
                    s_next.flow    = WDATA[umlc_pkg::CFG_FLOW_LSB +: 4];
                    s_next.dsr_cfg = WDATA[umlc_pkg::CFG_DSR_BIT];
                    s_next.dtr_cfg = WDATA[umlc_pkg::CFG_DTR_BIT];
                    s_next.dcd_cfg = WDATA[umlc_pkg::CFG_DCD_BIT];
                    s_next.psv     = WDATA[umlc_pkg::CFG_PSV_LSB +: 4];
                    s_next.cts_ovr = WDATA[umlc_pkg::CFG_CTS_OVR];
                end
                default: begin
                end
            endcase
        end

        if (RD) begin
            case (ADDR)
                umlc_pkg::OFF_CTRL: begin
                    s_next.rdata[1:0] = s_reg.mode;
                    s_next.rdata[umlc_pkg::CTRL_CARRIER]  = s_reg.carrier;
                    s_next.rdata[umlc_pkg::CTRL_MUX_START] = s_reg.mux_on;
                    s_next.rdata[umlc_pkg::CTRL_PORT_RDY] = s_reg.port_rdy;
                    s_next.rdata[umlc_pkg::CTRL_MUX_FCON] = s_reg.mux_fcon;
                    s_next.rdata[umlc_pkg::CTRL_OK_CLR]   = s_reg.ok_flag;
                end
                umlc_pkg::OFF_CFG: begin
                    s_next.rdata[umlc_pkg::CFG_BAUD_LSB +: 8]  = s_reg.baud;
                    s_next.rdata[umlc_pkg::CFG_FRAME_LSB +: 4] = s_reg.frame;
                    s_next.rdata[umlc_pkg::CFG_FLOW_LSB +: 4]  = s_reg.flow;
                    s_next.rdata[umlc_pkg::CFG_DSR_BIT]        = s_reg.dsr_cfg;
                    s_next.rdata[umlc_pkg::CFG_DTR_BIT]        = s_reg.dtr_cfg;
                    s_next.rdata[umlc_pkg::CFG_DCD_BIT]        = s_reg.dcd_cfg;
                    s_next.rdata[umlc_pkg::CFG_PSV_LSB +: 4]   = s_reg.psv;
                    s_next.rdata[umlc_pkg::CFG_CTS_OVR]        = s_reg.cts_ovr;
                end
                umlc_pkg::OFF_STATUS: begin
                    s_next.rdata[0] = running;
                    s_next.rdata[1] = s_reg.asleep;
                    s_next.rdata[2] = s_reg.rts_stop;
                    s_next.rdata[3] = s_reg.auto_done;
                    s_next.rdata[4] = tx_busy;
                    s_next.rdata[6:5] = s_reg.chars_after;
                    s_next.rdata[7] = cts_lvl;
                end
                umlc_pkg::OFF_MUXCH: s_next.rdata[2:0] = ch_kind(MUX_CH, HAS_SIM);
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_reg <= '{phase: ST_FLOAT, tri_cnt: 8'h00, mode: MD_CMD,
                       carrier: 1'b0, mux_on: 1'b0, mux_fcon: 1'b1,
                       port_rdy: 1'b1,
                       baud: umlc_pkg::BAUD_AUTO,
                       frame: umlc_pkg::FRAME_AUTO,
                       flow: umlc_pkg::FLOW_HW,
                       dsr_cfg: umlc_pkg::DSR_FOLLOW, dtr_cfg: umlc_pkg::DTR_ONLINE,
                       dcd_cfg: umlc_pkg::DCD_FOLLOW, psv: umlc_pkg::PSV_OFF,
                       cts_ovr: umlc_pkg::LVL_ON, auto_done: 1'b0, ok_flag: 1'b0,
                       dtr_prev: 1'b1, rts_prev: 1'b1, asleep: 1'b0, rts_stop: 1'b0,
                       chars_after: 2'h0, rdata: 32'h0000_0000};
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // CTS OFF says the port is not taking data; with PSV_RTS and no hardware flow it also marks that active mode has been left.
    always_comb begin
        cts_lvl = umlc_pkg::LVL_ON;
        if (s_reg.mux_on) cts_lvl = s_reg.asleep ? umlc_pkg::LVL_OFF : umlc_pkg::LVL_ON;
        else if (hw_flow) cts_lvl = s_reg.port_rdy ? umlc_pkg::LVL_ON : umlc_pkg::LVL_OFF;
        else if (s_reg.psv == umlc_pkg::PSV_RTS)
            cts_lvl = s_reg.asleep ? umlc_pkg::LVL_OFF : umlc_pkg::LVL_ON;
        else if (!EARLY_VER) cts_lvl = s_reg.cts_ovr;
    end

    assign RDATA       = s_reg.rdata;
    assign RXD_OUT     = running ? tx_line : umlc_pkg::LVL_OFF;
    assign CTS_OUT     = running ? cts_lvl : umlc_pkg::LVL_ON;
    assign DSR_OUT     = (s_reg.dsr_cfg && s_reg.mode != MD_DATA) ? umlc_pkg::LVL_OFF
                                                                   : umlc_pkg::LVL_ON;
    assign DCD_OUT     = (s_reg.dcd_cfg && !s_reg.carrier) ? umlc_pkg::LVL_OFF
                                                            : umlc_pkg::LVL_ON;
    assign RXD_OE_N    = (s_reg.phase == ST_FLOAT);
    assign CTS_OE_N    = (s_reg.phase == ST_FLOAT);
    assign DSR_OE_N    = (s_reg.phase == ST_FLOAT);
    assign DCD_OE_N    = (s_reg.phase == ST_FLOAT);
    assign TXD_PULLUP  = 1'b1;
    assign RX_TO_CMD   = running && RX_CHAR && s_reg.mode != MD_DATA && !s_reg.asleep;
    assign RX_DISCARD  = running && RX_CHAR && s_reg.asleep;
    assign MUX_CH_KIND = s_reg.mux_on ? ch_kind(MUX_CH, HAS_SIM) : 3'h0;
    assign MUX_FC_ON   = s_reg.mux_on && s_reg.mux_fcon && s_reg.port_rdy;
    assign ACTIVE_MODE = running && !s_reg.asleep;

    ////////////////////////////////////////////////////////////////////////////////////
    chk_dsr_follow: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (s_reg.dsr_cfg && s_reg.mode == MD_DATA) |-> DSR_OUT == 1'b0)
        else $error("DSR not ON in data mode");
    chk_dtr_online: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (running && s_reg.dtr_cfg && s_reg.mode == MD_DATA && !WR && !s_reg.dtr_prev
         && DTR_IN) |=> (s_reg.mode == MD_ONLINE_CMD && s_reg.ok_flag))
        else $error("DTR drop did not enter online command mode");
    chk_dcd_carrier: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        s_reg.dcd_cfg |-> DCD_OUT == !s_reg.carrier)
        else $error("DCD does not follow carrier");
    chk_mux_start: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(s_reg.mux_on) |-> $past(WR) && $past(ADDR) == umlc_pkg::OFF_CTRL)
        else $error("Mux enabled without start command");
    sequence float_phase;
        RXD_OE_N [*2];
    endsequence
    chk_pins_float: assert property (@(posedge CORE_CLK)
        $rose(RESET_N) |-> float_phase ##[1:30] !RXD_OE_N && RXD_OUT)
        else $error("Pins did not float then take reset level");
    chk_rxd_idle: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        !tx_busy |-> RXD_OUT == 1'b1)
        else $error("Data output not idle high");
    chk_cts_hwflow: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (running && hw_flow && !s_reg.mux_on) |-> CTS_OUT == !s_reg.port_rdy)
        else $error("CTS does not follow port readiness");
    chk_rts_stop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (hw_flow && RTS_IN && s_reg.rts_prev) ##1 s_reg.rts_stop |-> !tx_start)
        else $error("Transmit started after RTS OFF");
    chk_first_lost: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (running && RX_CHAR && s_reg.asleep) |-> RX_DISCARD && !RX_TO_CMD)
        else $error("Character while idle not discarded");
endmodule : umlc_top

// File: tb/umlc_dte_model.sv
// DTE model: drives the handshake inputs and the data line of the port.
// Assumes the bench asks for line levels through plain request bits.
`timescale 1ns/1ps
module umlc_dte_model (
    input  wire logic clk,
    input  wire logic rts_on,
    input  wire logic dtr_on,
    input  wire logic send,
    input  wire logic cts_out,
    output logic      rts_in,
    output logic      dtr_in,
    output logic      txd_in,
    output logic      rx_char = 1'b0
);
    // Released lines rest high through the pull-ups of the port.
    assign rts_in = rts_on ? umlc_pkg::LVL_ON : umlc_pkg::LVL_OFF;
    assign dtr_in = dtr_on ? umlc_pkg::LVL_ON : umlc_pkg::LVL_OFF;
    assign txd_in = 1'b1;
    // A character is offered only while clear-to-send is ON.
    always @(posedge clk) rx_char <= send && (cts_out === umlc_pkg::LVL_ON);
endmodule : umlc_dte_model

// File: tb/umlc_top_tb.sv
// Testbench of the modem line control block against a DTE model.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module umlc_top_tb;
    localparam int BITC = 4;
    logic        clk, rst_n, wr, rd, tx_valid, rts_on, dtr_on, send, txd, txd_pu, rxd;
    logic        rxd_oe_n, cts, cts_oe_n, dsr, dsr_oe_n, dcd, dcd_oe_n, rts, dtr;
    logic        tx_ready, rx_char, rx_cmd, rx_disc, mux_fc, active;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, r;
    logic [7:0]  tx_data;
    logic [9:0]  fr;
    logic [2:0]  mux_ch, kind;
    logic [15:0] seed = 16'haaa6;
    int          error_cnt = 0;
    int          checks = 0;
    int          n;
    umlc_top #(.BIT_CYC(BITC)) umlc_top_i (.CORE_CLK(clk), .RESET_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TXD_IN(txd), .TXD_PULLUP(txd_pu),
        .RXD_OUT(rxd), .RXD_OE_N(rxd_oe_n), .CTS_OUT(cts), .CTS_OE_N(cts_oe_n),
        .DSR_OUT(dsr), .DSR_OE_N(dsr_oe_n), .DCD_OUT(dcd), .DCD_OE_N(dcd_oe_n),
        .RTS_IN(rts), .DTR_IN(dtr), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_READY(tx_ready), .RX_CHAR(rx_char), .RX_TO_CMD(rx_cmd), .RX_DISCARD(rx_disc),
        .MUX_CH(mux_ch), .MUX_CH_KIND(kind), .MUX_FC_ON(mux_fc), .ACTIVE_MODE(active));
    umlc_dte_model umlc_dte_model_i (.clk(clk), .rts_on(rts_on), .dtr_on(dtr_on),
        .send(send), .cts_out(cts), .rts_in(rts), .dtr_in(dtr), .txd_in(txd),
        .rx_char(rx_char));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] xs(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction : xs
    function automatic logic [31:0] kind_of(input int ch);
        return (ch == 0) ? 0 : (ch <= 5) ? 1 : (ch == 6) ? 2 : 3;
    endfunction : kind_of
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // Read data stand only in the cycle after the strobe, so they are caught there.
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask : rreg
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000 error_cnt++;
        give_verdict();
    end
    initial begin
        {rst_n, wr, rd, tx_valid, rts_on, dtr_on, send} = '0;
        {addr, wdata, tx_data, mux_ch} = '0;
        #12 cmp(rxd_oe_n & cts_oe_n & dsr_oe_n & dcd_oe_n, 1);
        cmp(rxd, umlc_pkg::LVL_OFF);
        cmp(cts, umlc_pkg::LVL_ON);
        repeat (8) @(posedge clk);
        rst_n  <= 1'b1;
        rts_on <= 1'b1;
        n = 0;
        while (rxd_oe_n !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        cmp(n >= umlc_pkg::TRI_CYC, 1);
        repeat (3) @(posedge clk);
        #1 cmp(active, 1);
        cmp(cts, umlc_pkg::LVL_ON);
        cmp({dsr, txd_pu, txd, rxd}, 4'hf);
        rreg(umlc_pkg::OFF_CFG);
        cmp(r, 32'h00073000);
        rreg(umlc_pkg::OFF_CTRL);
        cmp(r[2:0], 0);
        rreg(4'h2);
        cmp(r, 0);
        @(posedge clk);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        #1 cmp({rx_cmd, rx_disc}, 2'b10);
        seed = xs(seed);
        mux_ch <= seed[2:0];
        @(posedge clk);
        #1 cmp(kind, 0);
        wreg(umlc_pkg::OFF_CTRL, 32'h1 << umlc_pkg::CTRL_MUX_START);
        for (int ch = 0; ch < 8; ch++) begin
            mux_ch <= ch[2:0];
            rreg(umlc_pkg::OFF_MUXCH);
            cmp(kind, kind_of(ch));
            cmp(r, kind_of(ch));
        end
        wreg(umlc_pkg::OFF_CTRL, 32'h1 << umlc_pkg::CTRL_MUX_STOP);
        wreg(umlc_pkg::OFF_CTRL, 32'h3);
        #1 cmp({dsr, dcd, cts}, 3'b001);
        seed = xs(seed);
        fr = {1'b1, seed[7:0], 1'b0};
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data  <= seed[7:0];
        #1 n = 0;
        while (tx_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        tx_valid <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            repeat (i == 0 ? 2 : BITC) @(posedge clk);
            #1 cmp(rxd, fr[i]);
        end
        dtr_on <= 1'b1;
        repeat (4) @(posedge clk);
        dtr_on <= 1'b0;
        repeat (4) @(posedge clk);
        rreg(umlc_pkg::OFF_CTRL);
        cmp(r[1:0], 2);
        cmp({dsr, rxd}, 2'b11);
        wreg(umlc_pkg::OFF_CTRL, 32'h0);
        #1 cmp(dcd, 1);
        wreg(umlc_pkg::OFF_CFG, 32'h00270000);
        rts_on <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({active, cts}, 2'b01);
        rts_on <= 1'b1;
        repeat (2) @(posedge clk);
        #1 cmp({active, cts}, 2'b10);
        give_verdict();
    end
endmodule : umlc_top_tb
